//--- eth_irq_mask_and_ring_kick.sv
// Contract
// - Interrupt output high when any event flag and its mask bit are set.
// - Interrupt stays until flag written one or mask bit written zero.
// - Hardware reset clears the whole interrupt mask register.
// - Mask bits 31 to 19, zero blocks a source, one passes it.
// - Event flags record every event each clock regardless of mask. Code drops events and holds all flags clear during local soft reset.
// - Any write to receive-active register sets bit 24. Code leaves bit 24 clear if the write comes while controller enable is clear.
// - Receive ring polled while receive-active and controller enable set.
// - Polled receive descriptor not empty clears receive-active, stops polling.
// - Receive-active cleared by reset and when controller enable clears.
// - Any write to transmit-active register sets bit 24. Code leaves bit 24 clear if the write comes while controller enable is clear.
// - Transmit ring polled while transmit-active and controller enable set.
// - Polled transmit descriptor not ready clears transmit-active, stops polling.
// - Transmit-active cleared by reset, enable clear, or local soft reset.
// - Enable permits traffic; clearing it resets DMA and descriptor logic.
// - Bus error sets its event flag and clears controller enable.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module eth_irq_mask_and_ring_kick
  import ring_kick_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_EVENTS-1:0] event_in,
  input wire ring_stop_t ring_stop,
  output ring_ctl_t ring_ctl,
  output logic irq
);

  typedef enum logic [1:0] {CTL_RUN, CTL_SOFT_RESET} ctl_state_t;

  // Write channel state
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic wr_fire;
  logic [DATA_W-1:0] wbits;

  // Read channel state
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Block state
  logic [NUM_EVENTS-1:0] mask_reg, mask_next;
  logic rx_active_reg, rx_active_next;
  logic tx_active_reg, tx_active_next;
  logic enable_reg, enable_next;
  ctl_state_t ctl_state_reg, ctl_state_next;
  logic [SOFT_CNT_W-1:0] soft_cnt_reg, soft_cnt_next;
  ring_ctl_t ring_ctl_reg, ring_ctl_next;
  logic soft_clear;
  logic [NUM_EVENTS-1:0] flag_w1c;
  logic [NUM_EVENTS-1:0] flags;

  // Byte strobes widened to a bit mask
  always_comb begin
    wbits = '0;
    for (int b = 0; b < 4; b++) begin
      wbits[b*8 +: 8] = {8{wstrb_reg[b]}};
    end
  end

  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign soft_clear = (ctl_state_reg == CTL_SOFT_RESET);

  // AXI write channel: address and data accepted in either order
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      case (waddr_reg)
        OFF_EVENT_FLAG, OFF_EVENT_MASK, OFF_RX_RING_ACTIVE,
        OFF_TX_RING_ACTIVE, OFF_ETHERNET_CONTROL: begin
          bresp_next = RESP_OKAY;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else if (ce) begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
    end
  end

  // AXI read channel: data returned one cycle after address taken
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rdata_next = '0;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr)
        OFF_EVENT_FLAG: begin
          rdata_next[EVENT_MSB:EVENT_LSB] = flags;
        end
        OFF_EVENT_MASK: begin
          rdata_next[EVENT_MSB:EVENT_LSB] = mask_reg;
        end
        OFF_RX_RING_ACTIVE: begin
          rdata_next[RING_ACTIVE_BIT] = rx_active_reg;
        end
        OFF_TX_RING_ACTIVE: begin
          rdata_next[RING_ACTIVE_BIT] = tx_active_reg;
        end
        OFF_ETHERNET_CONTROL: begin
          rdata_next[CTRL_ENABLE_BIT] = enable_reg;
          rdata_next[CTRL_SOFT_RESET_BIT] = soft_clear;
        end
        default: begin
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      arready_reg <= arready_next || (!arready_reg && !rvalid_reg);
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Event flags, write one to clear
  always_comb begin
    flag_w1c = '0;
    if (wr_fire && waddr_reg == OFF_EVENT_FLAG) begin
      flag_w1c = wdata_reg[EVENT_MSB:EVENT_LSB] & wbits[EVENT_MSB:EVENT_LSB];
    end
  end

  event_flag_bank u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear_all(soft_clear),
    .event_in(event_in),
    .w1c(flag_w1c),
    .mask_next(mask_next),
    .flags(flags),
    .irq(irq)
  );

  // Mask, enable, ring-active flags and local soft reset
  always_comb begin
    mask_next = mask_reg;
    enable_next = enable_reg;
    rx_active_next = rx_active_reg;
    tx_active_next = tx_active_reg;
    ctl_state_next = ctl_state_reg;
    soft_cnt_next = soft_cnt_reg;
    // Hardware stops polling on an exhausted ring; a same-cycle kick wins
    if (ring_ctl_reg.rx_poll && ring_stop.rx_desc_full) begin
      rx_active_next = 1'b0;
    end
    if (ring_ctl_reg.tx_poll && ring_stop.tx_desc_unready) begin
      tx_active_next = 1'b0;
    end
    if (wr_fire) begin
      case (waddr_reg)
        OFF_EVENT_MASK: begin
          mask_next = (mask_reg & ~wbits[EVENT_MSB:EVENT_LSB]) |
                      (wdata_reg[EVENT_MSB:EVENT_LSB] & wbits[EVENT_MSB:EVENT_LSB]);
        end
        OFF_RX_RING_ACTIVE: begin
          rx_active_next = 1'b1;
        end
        OFF_TX_RING_ACTIVE: begin
          tx_active_next = 1'b1;
        end
        OFF_ETHERNET_CONTROL: begin
          if (wbits[CTRL_ENABLE_BIT]) begin
            enable_next = wdata_reg[CTRL_ENABLE_BIT];
          end
          if (wbits[CTRL_SOFT_RESET_BIT] && wdata_reg[CTRL_SOFT_RESET_BIT]) begin
            ctl_state_next = CTL_SOFT_RESET;
            soft_cnt_next = '0;
            mask_next = EVENT_MASK_RESET;
            enable_next = ENABLE_RESET;
          end
        end
        default: begin
        end
      endcase
    end
    if (event_in[BUS_ERROR_IDX]) begin
      enable_next = 1'b0;
    end
    case (ctl_state_reg)
      CTL_RUN: begin
      end
      CTL_SOFT_RESET: begin
        // Local reset holds mask, enable and both ring-active flags at their reset values
        mask_next = EVENT_MASK_RESET;
        enable_next = ENABLE_RESET;
        tx_active_next = RING_ACTIVE_RESET;
        rx_active_next = RING_ACTIVE_RESET;
        if (soft_cnt_reg == SOFT_CNT_W'(SOFT_RESET_CYCLES - 1)) begin
          ctl_state_next = CTL_RUN;
        end else begin
          soft_cnt_next = soft_cnt_reg + 1'b1;
        end
      end
      default: begin
        ctl_state_next = CTL_RUN;
      end
    endcase
    if (!enable_next) begin
      rx_active_next = 1'b0;
      tx_active_next = 1'b0;
    end
  end

  always_comb begin
    ring_ctl_next.enable = enable_next;
    ring_ctl_next.dma_reset = !enable_next;
    ring_ctl_next.rx_poll = rx_active_next && enable_next;
    ring_ctl_next.tx_poll = tx_active_next && enable_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= EVENT_MASK_RESET;
      enable_reg <= ENABLE_RESET;
      rx_active_reg <= RING_ACTIVE_RESET;
      tx_active_reg <= RING_ACTIVE_RESET;
      ctl_state_reg <= CTL_RUN;
      soft_cnt_reg <= '0;
      ring_ctl_reg <= '{enable: 1'b0, dma_reset: 1'b1, rx_poll: 1'b0, tx_poll: 1'b0};
    end else if (ce) begin
      mask_reg <= mask_next;
      enable_reg <= enable_next;
      rx_active_reg <= rx_active_next;
      tx_active_reg <= tx_active_next;
      ctl_state_reg <= ctl_state_next;
      soft_cnt_reg <= soft_cnt_next;
      ring_ctl_reg <= ring_ctl_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ring_ctl = ring_ctl_reg;

endmodule

//--- ring_kick_pkg.sv
package ring_kick_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_EVENTS = 13;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_EVENT_FLAG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RX_RING_ACTIVE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TX_RING_ACTIVE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ETHERNET_CONTROL = 8'h24;

  // Field positions
  localparam int EVENT_LSB = 19;
  localparam int EVENT_MSB = 31;
  localparam int RING_ACTIVE_BIT = 24;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int BUS_ERROR_IDX = 22 - EVENT_LSB;

  // Reset values
  localparam logic [NUM_EVENTS-1:0] EVENT_MASK_RESET = 13'h0000;
  localparam logic [NUM_EVENTS-1:0] EVENT_FLAG_RESET = 13'h0000;
  localparam logic RING_ACTIVE_RESET = 1'b0;
  localparam logic ENABLE_RESET = 1'b0;

  // Local soft reset lasts this many clock cycles
  localparam int SOFT_RESET_CYCLES = 8;
  localparam int SOFT_CNT_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic dma_reset;
    logic rx_poll;
    logic tx_poll;
  } ring_ctl_t;

  typedef struct packed {
    logic rx_desc_full;
    logic tx_desc_unready;
  } ring_stop_t;

endpackage

//--- event_flag_bank.sv
`timescale 1ns/100ps
module event_flag_bank
  import ring_kick_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clear_all,
  input wire logic [NUM_EVENTS-1:0] event_in,
  input wire logic [NUM_EVENTS-1:0] w1c,
  input wire logic [NUM_EVENTS-1:0] mask_next,
  output logic [NUM_EVENTS-1:0] flags,
  output logic irq
);

  logic [NUM_EVENTS-1:0] flag_reg;
  logic [NUM_EVENTS-1:0] flag_next;
  logic irq_reg;
  logic irq_next;

  genvar i;
  generate
    for (i = 0; i < NUM_EVENTS; i++) begin : g_flag
      // Event set wins over a write-one-to-clear in the same cycle
      always_comb begin
        if (clear_all) begin
          flag_next[i] = EVENT_FLAG_RESET[i];
        end else if (event_in[i]) begin
          flag_next[i] = 1'b1;
        end else if (w1c[i]) begin
          flag_next[i] = 1'b0;
        end else begin
          flag_next[i] = flag_reg[i];
        end
      end
    end
  endgenerate

  always_comb begin
    irq_next = |(flag_next & mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= EVENT_FLAG_RESET;
      irq_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
      irq_reg <= irq_next;
    end
  end

  assign flags = flag_reg;
  assign irq = irq_reg;

endmodule

//--- eth_irq_mask_and_ring_kick_properties.sv
`timescale 1ns/100ps
module eth_irq_mask_and_ring_kick_properties
  import ring_kick_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_EVENTS-1:0] event_in,
  input wire ring_stop_t ring_stop,
  input wire ring_ctl_t ring_ctl,
  input wire logic irq
);
  logic wrote;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  // Until the first write completes the mask is still all zero
  always_ff @(posedge aclk) wrote <= aresetn && (wrote || s_axi_bvalid);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  property p_reset_clear;
    disable iff (1'b0) !aresetn && ce |=> !irq && ring_ctl == 4'h4;
  endproperty
  property p_rx_poll_en;
    ring_ctl.rx_poll |-> ring_ctl.enable;
  endproperty
  property p_tx_poll_en;
    ring_ctl.tx_poll |-> ring_ctl.enable;
  endproperty
  property p_dma_reset;
    ring_ctl.dma_reset != ring_ctl.enable;
  endproperty
  property p_rx_stop;
    ring_ctl.rx_poll && ring_stop.rx_desc_full && s_axi_awready |=> !ring_ctl.rx_poll;
  endproperty
  property p_tx_stop;
    ring_ctl.tx_poll && ring_stop.tx_desc_unready && s_axi_awready |=> !ring_ctl.tx_poll;
  endproperty
  property p_bus_error;
    event_in[BUS_ERROR_IDX] |=> !ring_ctl.enable;
  endproperty
  property p_irq_quiet;
    !wrote && !s_axi_bvalid |-> !irq;
  endproperty
  property p_irq_hold;
    $fell(irq) && $past(aresetn) |-> $rose(s_axi_bvalid);
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_rd_hold;
    s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
  a_rx_poll_en: assert property (p_rx_poll_en) else $error("rx poll without enable");
  a_tx_poll_en: assert property (p_tx_poll_en) else $error("tx poll without enable");
  a_dma_reset: assert property (p_dma_reset) else $error("dma reset wrong");
  a_rx_stop: assert property (p_rx_stop) else $error("rx poll not stopped");
  a_tx_stop: assert property (p_tx_stop) else $error("tx poll not stopped");
  a_bus_error: assert property (p_bus_error) else $error("enable kept on bus error");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with reset mask");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind eth_irq_mask_and_ring_kick eth_irq_mask_and_ring_kick_properties u_props (
  .aclk, .aresetn, .ce, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .event_in, .ring_stop, .ring_ctl, .irq);

//--- eth_irq_mask_and_ring_kick_tb.sv
`timescale 1ns/100ps
module eth_irq_mask_and_ring_kick_tb
  import ring_kick_pkg::*;
;
  logic aclk, aresetn, ce, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [12:0] event_in;
  ring_stop_t ring_stop;
  ring_ctl_t ring_ctl;
  int n_mismatch = 0;
  int checks_done = 0;
  eth_irq_mask_and_ring_kick dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .event_in, .ring_stop, .ring_ctl, .irq);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      // Accept one cycle late so the read data must stand through a wait state
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One-cycle pulse on the event and descriptor-stop inputs
  task automatic pulse(input logic [12:0] e, input ring_stop_t s);
    @(posedge aclk);
    event_in <= e;
    ring_stop <= s;
    @(posedge aclk);
    event_in <= 13'h0000;
    ring_stop <= 2'h0;
    @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    event_in = 13'h0000;
    ring_stop = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_EVENT_MASK);
    chk(d, 32'h0);
    chk(ring_ctl, 32'h4);
    wr(OFF_ETHERNET_CONTROL, 32'h2);
    chk(r, RESP_OKAY);
    chk(ring_ctl, 32'h8);
    pulse(13'h1ff7, 2'h0);
    rd(OFF_EVENT_FLAG);
    chk(d, 32'hffb8_0000);
    chk(irq, 32'h0);
    wr(OFF_EVENT_MASK, 32'hffff_ffff);
    chk(irq, 32'h1);
    rd(OFF_EVENT_MASK);
    chk(d, 32'hfff8_0000);
    for (int i = 0; i < 13; i++) begin
      if (i == BUS_ERROR_IDX) continue;
      wr(OFF_EVENT_MASK, 32'h1 << (19 + i));
      chk(irq, 32'h1);
      wr(OFF_EVENT_FLAG, 32'h1 << (19 + i));
      chk(irq, 32'h0);
    end
    pulse(13'h1000, 2'h0);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h1);
    wr(OFF_EVENT_MASK, 32'h0);
    chk(irq, 32'h0);
    for (int k = 0; k < 2; k++) begin
      a = k ? OFF_RX_RING_ACTIVE : OFF_TX_RING_ACTIVE;
      wr(a, k ? 32'h0 : 32'hffff_ffff);
      chk(ring_ctl[k], 32'h1);
      rd(a);
      chk(d, 32'h0100_0000);
      pulse(13'h0000, 2'h1 << k);
      chk(ring_ctl[k], 32'h0);
      rd(a);
      chk(d, 32'h0);
    end
    wr(OFF_RX_RING_ACTIVE, 32'h0);
    wr(OFF_TX_RING_ACTIVE, 32'h0);
    chk(ring_ctl, 32'hb);
    wr(OFF_ETHERNET_CONTROL, 32'h0);
    chk(ring_ctl, 32'h4);
    wr(OFF_ETHERNET_CONTROL, 32'h2);
    chk(ring_ctl, 32'h8);
    wr(OFF_RX_RING_ACTIVE, 32'h0);
    pulse(13'h0008, 2'h0);
    chk(ring_ctl, 32'h4);
    rd(OFF_EVENT_FLAG);
    chk(d, 32'h8040_0000);
    wr(OFF_ETHERNET_CONTROL, 32'h2);
    wr(OFF_TX_RING_ACTIVE, 32'h0);
    wr(OFF_EVENT_MASK, 32'hffff_ffff);
    wr(OFF_ETHERNET_CONTROL, 32'h3);
    chk(ring_ctl.tx_poll, 32'h0);
    repeat (10) @(posedge aclk);
    chk(ring_ctl, 32'h4);
    rd(OFF_TX_RING_ACTIVE);
    chk(d, 32'h0);
    rd(OFF_EVENT_MASK);
    chk(d, 32'h0);
    // Only the top byte lane is written
    s_axi_wstrb <= 4'h8;
    wr(OFF_EVENT_MASK, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rd(OFF_EVENT_MASK);
    chk(d, 32'hff00_0000);
    wr(8'h40, 32'hffff_ffff);
    chk(r, RESP_SLVERR);
    rd(8'h40);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    end_sim();
  end
endmodule
